// [hdl/hpcb_core.sv]
// host port and shared control block interpreter
// assumes a memory master that answers mem_req with mem_ack; memory
// reads return mem_rdata in the ack cycle; port strobe and attention
// are active-high levels; the register bus carries status and controls
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
module hpcb_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // host pins
  input wire logic channel_attention_strobe,
  input wire logic port_strobe,
  input wire logic [15:0] port_data,
  output logic irq,
  // strap pins
  input wire logic big_endian,
  input wire logic half_bus,
  // unit events from the datapath
  input wire logic cmd_done_irq,
  input wire logic cmd_list_end,
  input wire logic frame_rx,
  input wire logic rx_out_of_res,
  input wire logic rfd_suspend,
  // memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // avalon slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ==========================================================
  // register map
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_BASE = 4'h1;
  localparam logic [3:0] REG_SCBOFF = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_ROOT = 4'h4;
  localparam logic [3:0] REG_DUMP = 4'h5;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_READ = 6'b000010,
    ST_CLEAR = 6'b000100,
    ST_STAT = 6'b001000,
    ST_TEST = 6'b010000,
    ST_DUMP = 6'b100000
  } hpcb_state_t;
  typedef enum logic [2:0] {
    CU_IDLE = 3'b001,
    CU_SUSP = 3'b010,
    CU_ACTIVE = 3'b100
  } hpcb_cu_t;
  typedef enum logic [3:0] {
    RU_IDLE = 4'b0001,
    RU_NORES = 4'b0010,
    RU_SUSP = 4'b0100,
    RU_READY = 4'b1000
  } hpcb_ru_t;

  hpcb_state_t state;
  hpcb_cu_t cu;
  hpcb_ru_t ru;
  logic [1:0] mode;
  logic [31:0] base;
  logic [15:0] scb_off;
  logic [31:0] root_ptr;
  logic [31:0] dump_ptr;
  logic [31:0] test_ptr;
  logic [15:0] port_lo;
  logic port_half;
  logic frozen;
  logic ca_pend;
  logic [31:0] ctl;
  logic [3:0] stat;
  logic tld;
  logic irq_gap;
  logic [1:0] gap_cnt;
  logic ca_fall;
  logic port_fall;
  logic [31:0] rd_swapped;
  logic [3:0] new_ev;
  logic [3:0] rus_code;
  logic [2:0] cus_code;
  logic [31:0] scb_addr;
  logic port_go;
  logic soft_rst;

  // ==========================================================
  // input synchronisers and read-data byte swap
  hpcb_sync u_ca (
    .core_clk(core_clk),
    .rst(rst),
    .din(channel_attention_strobe),
    .fall(ca_fall)
  );
  hpcb_sync u_port (
    .core_clk(core_clk),
    .rst(rst),
    .din(port_strobe),
    .fall(port_fall)
  );
  hpcb_swap u_swap (
    .big_endian(big_endian),
    .half_bus(half_bus),
    .din(mem_rdata),
    .dout(rd_swapped)
  );

  // ==========================================================
  // port access: two halfwords then execute
  assign port_go = port_fall & port_half;
  assign soft_rst = port_go & (port_lo[2:0] == {1'b0, hpcb_pkg::PORT_RESET});
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_half <= 1'b0;
      port_lo <= 16'h0000;
      frozen <= 1'b0;
    end else if (port_fall) begin
      port_half <= ~port_half;
      if (!port_half) begin
        port_lo <= port_data;
        frozen <= 1'b1;
      end else begin
        frozen <= 1'b0;
      end
    end
  end

  // pointers loaded by the port; low four bits forced by alignment
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      root_ptr <= hpcb_pkg::ROOT_PTR_RESET;
      dump_ptr <= 32'h0000_0000;
      test_ptr <= 32'h0000_0000;
    end else if (port_go) begin
      unique case (port_lo[1:0])
        hpcb_pkg::PORT_SELFTEST: test_ptr <= {port_data, port_lo[15:4], 4'h0};
        hpcb_pkg::PORT_ROOTPTR: root_ptr <= {port_data, port_lo[15:4], 4'h0};
        hpcb_pkg::PORT_DUMP: dump_ptr <= {port_data, port_lo[15:4], 4'h0};
        hpcb_pkg::PORT_RESET: ;
      endcase
    end
  end

  // ==========================================================
  // attention latch, cleared before the control word read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ca_pend <= 1'b0;
    end else if (soft_rst) begin
      ca_pend <= 1'b0;
    end else if (ca_fall) begin
      ca_pend <= 1'b1;
    end else if (state == ST_IDLE && !frozen) begin
      ca_pend <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer: read control word, act, clear, write status
  assign scb_addr = hpcb_pkg::hpcb_addr(mode, base, scb_off, mode != hpcb_pkg::MODE_LINEAR);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      ctl <= 32'h0000_0000;
    end else if (soft_rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (port_go && port_lo[1:0] == hpcb_pkg::PORT_SELFTEST) begin
            state <= ST_TEST;
          end else if (port_go && port_lo[1:0] == hpcb_pkg::PORT_DUMP) begin
            state <= ST_DUMP;
          end else if (ca_pend && !frozen) begin
            state <= ST_READ;
          end
        end
        ST_READ: if (mem_ack) begin
          ctl <= rd_swapped;
          state <= ST_CLEAR;
        end
        ST_CLEAR: if (mem_ack) state <= ST_STAT;
        ST_STAT: if (mem_ack) state <= ST_IDLE;
        ST_TEST: if (mem_ack) state <= ST_IDLE;
        ST_DUMP: if (mem_ack) state <= ST_IDLE;
      endcase
    end
  end

  // memory request outputs
  always_comb begin
    mem_req = !(state == ST_IDLE);
    mem_we = state != ST_READ;
    mem_addr = scb_addr;
    mem_wdata = 32'h0000_0000;
    unique case (state)
      ST_STAT: mem_wdata = {16'h0000, stat, 1'b0, cus_code, rus_code, tld, 3'h0};
      ST_TEST: begin
        mem_addr = test_ptr;
        mem_wdata = hpcb_pkg::SELFTEST_SIG;
      end
      ST_DUMP: begin
        mem_addr = dump_ptr;
        mem_wdata = {16'h0000, stat, 1'b0, cus_code, rus_code, tld, 3'h0};
      end
      default: ;
    endcase
    if (mode == hpcb_pkg::MODE_COMPAT) mem_addr[31:24] = 8'h00;
  end

  // ==========================================================
  // command unit
  wire cmd_act = state == ST_READ && mem_ack;
  wire [2:0] command_unit_opcode = rd_swapped[hpcb_pkg::CUC_LSB +: 3];
  wire [2:0] receive_unit_opcode = rd_swapped[hpcb_pkg::RUC_LSB +: 3];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cu <= CU_IDLE;
      tld <= 1'b0;
    end else if (soft_rst) begin
      cu <= CU_IDLE;
    end else if (cmd_act) begin
      unique case (command_unit_opcode)
        hpcb_pkg::OP_START: cu <= CU_ACTIVE;
        hpcb_pkg::OP_RESUME: if (cu == CU_SUSP) cu <= CU_ACTIVE;
        hpcb_pkg::OP_SUSPEND: if (cu == CU_ACTIVE) cu <= CU_SUSP;
        hpcb_pkg::OP_ABORT: cu <= CU_IDLE;
        hpcb_pkg::OP_TLOAD, hpcb_pkg::OP_TRESTART: tld <= mode != hpcb_pkg::MODE_COMPAT;
        default: ;
      endcase
    end else if (cu == CU_ACTIVE && cmd_list_end) begin
      cu <= CU_IDLE;
    end
  end
  assign cus_code = (cu == CU_SUSP) ? 3'h1 : (cu == CU_ACTIVE) ? 3'h2 : 3'h0;

  // receive unit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ru <= RU_IDLE;
    end else if (soft_rst) begin
      ru <= RU_IDLE;
    end else if (cmd_act && receive_unit_opcode != hpcb_pkg::OP_NOP) begin
      unique case (receive_unit_opcode)
        hpcb_pkg::OP_START: ru <= RU_READY;
        hpcb_pkg::OP_RESUME: if (ru == RU_SUSP) ru <= RU_READY;
        hpcb_pkg::OP_SUSPEND: ru <= RU_SUSP;
        hpcb_pkg::OP_ABORT: ru <= RU_IDLE;
        default: ;
      endcase
    end else if (ru == RU_READY && rfd_suspend) begin
      ru <= RU_SUSP;
    end else if (ru == RU_READY && rx_out_of_res) begin
      ru <= RU_NORES;
    end
  end
  assign rus_code = (ru == RU_SUSP) ? hpcb_pkg::RUS_SUSP :
                    (ru == RU_NORES) ? hpcb_pkg::RUS_NORES :
                    (ru == RU_READY) ? hpcb_pkg::RUS_READY : hpcb_pkg::RUS_IDLE;

  // ==========================================================
  // events, acknowledge and interrupt
  wire cu_leave = cu == CU_ACTIVE && ((cmd_act && (command_unit_opcode == hpcb_pkg::OP_ABORT ||
                  command_unit_opcode == hpcb_pkg::OP_SUSPEND)) || (!cmd_act && cmd_list_end));
  wire ru_leave = ru == RU_READY && (rfd_suspend || rx_out_of_res ||
                  (cmd_act && (receive_unit_opcode == hpcb_pkg::OP_SUSPEND || receive_unit_opcode == hpcb_pkg::OP_ABORT)));
  assign new_ev = {cmd_done_irq, frame_rx, cu_leave, ru_leave};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat <= 4'h0;
    end else if (soft_rst) begin
      stat <= 4'h0;
    end else if (cmd_act) begin
      stat <= (stat & ~rd_swapped[hpcb_pkg::ACK_LSB +: 4]) | new_ev;
    end else begin
      stat <= stat | new_ev;
    end
  end

  // interrupt gap on a fresh event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_cnt <= 2'h0;
    end else if (irq && (new_ev & ~stat) != 4'h0) begin
      gap_cnt <= 2'(hpcb_pkg::INT_GAP_CYC);
    end else if (gap_cnt != 2'h0) begin
      gap_cnt <= gap_cnt - 2'h1;
    end
  end
  assign irq_gap = gap_cnt != 2'h0;
  // masked while a command is being processed
  assign irq = (stat != 4'h0) && !irq_gap && (state == ST_IDLE);

  // ==========================================================
  // avalon slave, zero wait states
  assign avs_waitrequest = 1'b0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode <= hpcb_pkg::MODE_COMPAT;
      base <= 32'h0000_0000;
      scb_off <= 16'h0000;
    end else if (avs_write) begin
      unique case (avs_address)
        REG_MODE: mode <= avs_writedata[1:0];
        REG_BASE: base <= avs_writedata;
        REG_SCBOFF: scb_off <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    unique case (avs_address)
      REG_MODE: avs_readdata = {30'h0, mode};
      REG_BASE: avs_readdata = base;
      REG_SCBOFF: avs_readdata = {16'h0000, scb_off};
      REG_STATUS: avs_readdata = {16'h0000, stat, 1'b0, cus_code, rus_code, tld, 3'h0};
      REG_ROOT: avs_readdata = root_ptr;
      REG_DUMP: avs_readdata = dump_ptr;
      default: avs_readdata = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // checks
  property p_zero_top;
    @(posedge core_clk) disable iff (rst) mode == hpcb_pkg::MODE_COMPAT |-> mem_addr[31:24] == 8'h00;
  endproperty
  a_zero_top: assert property (p_zero_top) else $error("top address byte not zero");
  property p_half_first;
    @(posedge core_clk) disable iff (rst) port_fall && !port_half |=> frozen && state == $past(state);
  endproperty
  a_half_first: assert property (p_half_first) else $error("first half acted");
  property p_clear_after_read;
    @(posedge core_clk) disable iff (rst) state == ST_READ && mem_ack |=> state == ST_CLEAR;
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("no clear");
  property p_sticky;
    @(posedge core_clk) disable iff (rst || soft_rst) stat[3] && !cmd_act |=> stat[3];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event lost");
  property p_gap;
    @(posedge core_clk) disable iff (rst) irq && new_ev[2] && !stat[2] |=> !irq;
  endproperty
  a_gap: assert property (p_gap) else $error("no fresh edge");
  property p_ca_latch;
    @(posedge core_clk) disable iff (rst) ca_fall && !soft_rst |=> ca_pend || state == ST_READ;
  endproperty
  a_ca_latch: assert property (p_ca_latch) else $error("attention lost");
  property p_cu_one;
    @(posedge core_clk) disable iff (rst) $onehot(cu) && $onehot(ru);
  endproperty
  a_cu_one: assert property (p_cu_one) else $error("unit state bad");
  property p_rus;
    @(posedge core_clk) disable iff (rst) ru == RU_READY |-> rus_code == 4'h4;
  endproperty
  a_rus: assert property (p_rus) else $error("bad state code");
  c_read: cover property (@(posedge core_clk) state == ST_READ ##[1:20] state == ST_STAT);
  c_port: cover property (@(posedge core_clk) port_go);
  c_gap: cover property (@(posedge core_clk) irq_gap);
endmodule : hpcb_core

// [hdl/hpcb_pkg.sv]
// constants shared by the host port and control block
// assumes one 100 MHz clock and an external memory master that
// performs the word accesses requested by the core
//
// Function
// - data bits 2..0 of a port write pick reset, self-test, pointer load or dump; the core checks bit 2 only for reset.
// - a port command is two halfword writes; act only after both halves.
// - first write freezes the machines and stores low half; second executes.
// - dump works while unresponsive; port reset reinitialises only this device.
// - self-test runs internally and writes its result to the supplied address.
// - compatibility mode uses 24-bit segmented addresses, top byte driven zero.
// - segmented address is base plus 16-bit offset; linear mode is 32-bit only.
// - a header past its segment end continues at the next contiguous address.
// - in segmented modes all offsets add to the single control block base.
// - big-endian supports only byte and halfword entities, never doublewords.
// - big-endian halfword bus uses data bits 15..0 with an internal byte swap.
// - command unit has idle, suspended and active states.
// - receive unit has idle, no-resources, suspended and ready states.
// - receive unit suspends only by host command or descriptor suspend flag.
// - after each attention read the control word, act, then clear it in memory.
// - events: command done with interrupt flag, frame, unit inactive, not ready.
// - events clear only by acknowledge; leftovers reassert interrupt after attention.
// - a new event while interrupt is high drops it briefly for a fresh edge.
// - attention latches on the strobe trailing edge; latch cleared before reading.
// - command unit opcode is control word bits 26..24 with seven codes.
// - receive unit opcode is control word bits 22..20; codes 5 to 7 reserved.
// - receive unit state goes in status bits 7..4 with codes 0,1,2,4,8,a; the core only ever reports codes 0,1,2,4.
package hpcb_pkg;
  // ==========================================================
  // port functions
  localparam logic [1:0] PORT_RESET = 2'h0;
  localparam logic [1:0] PORT_SELFTEST = 2'h1;
  localparam logic [1:0] PORT_ROOTPTR = 2'h2;
  localparam logic [1:0] PORT_DUMP = 2'h3;
  localparam logic [31:0] ROOT_PTR_RESET = 32'h00ff_fff4;
  localparam logic [31:0] SELFTEST_SIG = 32'h0000_0000; // arbitrary result word
  // ==========================================================
  // addressing modes
  localparam logic [1:0] MODE_COMPAT = 2'h0;
  localparam logic [1:0] MODE_SEG = 2'h1;
  localparam logic [1:0] MODE_LINEAR = 2'h2;
  // ==========================================================
  // control word fields
  localparam int ACK_LSB = 28;
  localparam int CUC_LSB = 24;
  localparam int RUC_LSB = 20;
  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_START = 3'h1;
  localparam logic [2:0] OP_RESUME = 3'h2;
  localparam logic [2:0] OP_SUSPEND = 3'h3;
  localparam logic [2:0] OP_ABORT = 3'h4;
  localparam logic [2:0] OP_TLOAD = 3'h5;
  localparam logic [2:0] OP_TRESTART = 3'h6;
  // ==========================================================
  // status word fields
  localparam int STAT_LSB = 12;
  localparam int CUS_LSB = 8;
  localparam int RUS_LSB = 4;
  localparam int TLD_BIT = 3;
  localparam logic [3:0] RUS_IDLE = 4'h0;
  localparam logic [3:0] RUS_SUSP = 4'h1;
  localparam logic [3:0] RUS_NORES = 4'h2;
  localparam logic [3:0] RUS_READY = 4'h4;
  localparam logic [3:0] RUS_NORBD = 4'h8;
  localparam logic [3:0] RUS_NORES_RBD = 4'ha;
  // ==========================================================
  // timing
  localparam int INT_GAP_NS = 20; // interrupt low time for fresh edge
  localparam int INT_GAP_CYC = (INT_GAP_NS + 9) / 10;
  // ==========================================================
  // shared arithmetic
  function automatic logic [31:0] hpcb_addr(input logic [1:0] mode, input logic [31:0] base,
                                            input logic [15:0] off, input logic seg);
    logic [31:0] a;
    a = seg ? base + {16'h0000, off} : base;
    if (mode == MODE_COMPAT) begin
      a[31:24] = 8'h00;
    end
    return a;
  endfunction : hpcb_addr
endpackage : hpcb_pkg

// [hdl/hpcb_sync.sv]
// two-flop synchroniser with trailing-edge pulse
// assumes a level input from another agent
`timescale 1ns/1ns
module hpcb_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // level in, pulse out
  input wire logic din,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;
  // synchronise then detect the falling edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign fall = s3 & ~s2;
endmodule : hpcb_sync

// [hdl/hpcb_swap.sv]
// byte-order crossover for 32-bit memory words
// assumes halfword entities only in big-endian order
`timescale 1ns/1ns
module hpcb_swap (
  // control
  input wire logic big_endian,
  input wire logic half_bus,
  // data
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  // swap bytes within each halfword; a narrow bus uses low lanes only
  always_comb begin
    if (!big_endian) begin
      dout = din;
    end else if (half_bus) begin
      dout = {16'h0000, din[7:0], din[15:8]};
    end else begin
      dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
    end
  end
endmodule : hpcb_swap

// [bench/hpcb_mem_model.sv]
// host memory model that answers the core's word requests
// assumes mem_req holds until mem_ack; the bench sets the control word
`timescale 1ns/1ns
module hpcb_mem_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // memory slave
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // bench side
  input wire logic [31:0] ctl_word,
  input wire logic [1:0] lat,
  input wire logic clr,
  output logic [31:0] rd_addr,
  output logic [31:0] wa [4],
  output logic [31:0] wd [4],
  output logic [2:0] wn
);
  logic [1:0] cnt;
  logic [31:0] junk;
  // ==========================================================
  // read data: control word only in the answer cycle, else noise
  assign mem_rdata = mem_ack ? ctl_word : junk;
  // answer after lat cycles and log every access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      wn <= 3'h0;
      rd_addr <= 32'h0;
      junk <= 32'h5a5a_a5a5;
    end else begin
      junk <= {junk[30:0], ~junk[31]};
      mem_ack <= 1'b0;
      if (clr) begin
        wn <= 3'h0;
      end else if (mem_req && !mem_ack) begin
        if (cnt != lat) begin
          cnt <= cnt + 2'h1; // slow answer
        end else begin
          cnt <= 2'h0;
          mem_ack <= 1'b1;
          if (mem_we) begin
            wa[wn[1:0]] <= mem_addr;
            wd[wn[1:0]] <= mem_wdata;
            wn <= wn + 3'h1;
          end else begin
            rd_addr <= mem_addr;
          end
        end
      end
    end
  end
endmodule : hpcb_mem_model

// [bench/hpcb_core_bench.sv]
// self-checking bench for the host port and control block
// assumes hpcb_mem_model as memory and a 100 MHz clock
`timescale 1ns/1ns
module hpcb_core_bench;
  logic core_clk, rst, ca, ps, irq, wrq, mreq, mwe, mack, clr, av_rd, av_wr, be, hb;
  logic [15:0] pd, rs;
  logic [4:0] ev;
  logic [3:0] aa;
  logic [1:0] lat;
  logic [2:0] wn;
  logic [31:0] awd, ard, maddr, mwd, mrd, ctl, rda, mrda, b, x, e, lr;
  logic [31:0] wa [4];
  logic [31:0] wd [4];
  int err_count, check_count, n;
  hpcb_core dut_u (.core_clk(core_clk), .rst(rst), .channel_attention_strobe(ca),
    .port_strobe(ps), .port_data(pd), .irq(irq), .big_endian(be), .half_bus(hb),
    .cmd_done_irq(ev[0]), .cmd_list_end(ev[1]), .frame_rx(ev[2]), .rx_out_of_res(ev[3]),
    .rfd_suspend(ev[4]), .mem_req(mreq), .mem_we(mwe), .mem_addr(maddr),
    .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd), .avs_address(aa),
    .avs_read(av_rd), .avs_write(av_wr), .avs_writedata(awd), .avs_readdata(ard),
    .avs_waitrequest(wrq));
  hpcb_mem_model mem_u (.core_clk(core_clk), .rst(rst), .mem_req(mreq), .mem_we(mwe),
    .mem_addr(maddr), .mem_wdata(mwd), .mem_ack(mack), .mem_rdata(mrd), .ctl_word(ctl),
    .lat(lat), .clr(clr), .rd_addr(mrda), .wa(wa), .wd(wd), .wn(wn));
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] exp_addr(input int m, input logic [31:0] bs,
                                           input logic [15:0] o);
    logic [31:0] a;
    a = bs + {16'h0000, o};
    if (m == 2) a = bs; // linear mode: base is the whole address
    if (m == 0) a[31:24] = 8'h00;
    return a;
  endfunction : exp_addr
  task rnd(output logic [31:0] r);
    rs = lfsr(lfsr(rs));
    r = {rs, lfsr(rs)};
  endtask : rnd
  task chk(input string nm, input logic [31:0] s, input logic [31:0] ex);
    check_count++;
    if (s !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, s);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    aa <= a;
    awd <= d;
    av_wr <= w;
    av_rd <= !w;
    do @(posedge core_clk); while (wrq !== 1'b0);
    rda = ard;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : bus
  task st(input logic [3:0] evx, input logic [2:0] cu, input logic [3:0] ru);
    bus(1'b0, 4'h3, 32'h0);
    chk("events", rda[15:12], evx);
    chk("cu state", rda[10:8], cu);
    chk("ru state", rda[7:4], ru);
  endtask : st
  task wt(input logic [2:0] k);
    n = 0;
    while (wn < k && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    chk("writes", wn, k);
    repeat (4) @(posedge core_clk);
  endtask : wt
  task clrlog;
    rnd(lr);
    @(posedge core_clk);
    clr <= 1'b1;
    lat <= lr[1:0];
    @(posedge core_clk);
    clr <= 1'b0;
  endtask : clrlog
  task att(input logic [31:0] c);
    clrlog;
    ctl <= c;
    ca <= 1'b1;
    n = 0;
    repeat (6) begin
      @(posedge core_clk);
      if (mreq === 1'b1) n++;
    end
    chk("fetch before trailing edge", n, 0);
    ca <= 1'b0;
    wt(3'h2);
    chk("command cleared", wd[0], 32'h0);
    chk("clear address", wa[0], mrda);
  endtask : att
  task port(input logic [15:0] d);
    @(posedge core_clk);
    pd <= d;
    ps <= 1'b1;
    repeat (2) @(posedge core_clk);
    ps <= 1'b0;
    repeat (5) @(posedge core_clk);
  endtask : port
  task pulse(input int i);
    @(posedge core_clk);
    ev <= 5'h01 << i;
    @(posedge core_clk);
    ev <= 5'h00;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize;
  end
  // ==========================================================
  // tests
  initial begin
    rst = 1; ca = 0; ps = 0; pd = 0; ev = 0; aa = 0; av_rd = 0; av_wr = 0; awd = 0;
    ctl = 0; lat = 0; clr = 0; rs = 16'h000c; err_count = 0; check_count = 0; be = 0; hb = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    chk("root pointer", rda, hpcb_pkg::ROOT_PTR_RESET);
    st(4'h0, 3'h0, 4'h0);
    bus(1'b1, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'hf, 32'h0);
    chk("unmapped", rda, 32'h0);
    $display("test reset done");
    // addressing: segment crossing first, then random bases
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 3; k++) begin
        rnd(b);
        rnd(x);
        if (k == 0) begin
          b = 32'h12ff_fff0;
          x = 32'h20;
        end
        bus(1'b1, 4'h0, m);
        bus(1'b1, 4'h1, b);
        bus(1'b1, 4'h2, {16'h0, x[15:2], 2'b00});
        att(32'h0);
        chk("control address", mrda, exp_addr(m, b, {x[15:2], 2'b00}));
      end
    end
    $display("test addressing done");
    // unit states and events
    att(32'h0110_0000);
    st(4'h0, 3'h2, 4'h4);
    pulse(2);
    st(4'h4, 3'h2, 4'h4);
    chk("irq", irq, 1'b1);
    @(posedge core_clk);
    ev <= 5'h01;
    @(posedge core_clk);
    ev <= 5'h00;
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (irq === 1'b0) n++;
    end
    chk("irq gap", n, hpcb_pkg::INT_GAP_CYC);
    pulse(4);
    st(4'hd, 3'h2, 4'h1);
    pulse(1);
    st(4'hf, 3'h0, 4'h1);
    att(32'hc020_0000);
    st(4'h3, 3'h0, 4'h4);
    chk("irq left", irq, 1'b1);
    pulse(3);
    st(4'h3, 3'h0, 4'h2);
    att(32'h3040_0000);
    st(4'h0, 3'h0, 4'h0);
    chk("irq clear", irq, 1'b0);
    att(32'h0110_0000);
    att(32'h0430_0000);
    st(4'h3, 3'h0, 4'h1);
    for (int i = 5; i < 8; i++) begin
      att((i << 24) | (i << 20) | 32'h3000_0000);
      st(4'h0, 3'h0, 4'h1);
      chk("timers loaded", rda[3], 1'b1);
    end
    $display("test units done");
    // port functions with aligned addresses
    for (int f = 1; f < 4; f++) begin
      rnd(e);
      e = e & 32'h00ff_fff0;
      clrlog;
      port({e[15:4], 2'b00, 2'(f)});
      repeat (10) @(posedge core_clk);
      chk("act on one half", wn, 3'h0);
      port(e[31:16]);
      if (f == 2) begin
        bus(1'b0, 4'h4, 32'h0);
        chk("root pointer", rda, e);
      end else begin
        wt(3'h1);
        chk("port write address", wa[0], e);
        x = (f == 1) ? hpcb_pkg::SELFTEST_SIG : 32'h0000_0018;
        chk("port write data", wd[0], x);
      end
    end
    bus(1'b0, 4'h5, 32'h0);
    chk("dump pointer", rda, e);
    att(32'h0110_0000);
    pulse(2);
    port(16'h0000);
    port(16'h0000);
    repeat (20) @(posedge core_clk);
    st(4'h0, 3'h0, 4'h0);
    chk("irq after reset", irq, 1'b0);
    att(32'h0);
    // big-endian: bytes of each halfword swapped in memory
    be <= 1'b1;
    att(32'h1001_0000);
    st(4'h0, 3'h2, 4'h4);
    hb <= 1'b1;
    att(32'h4100_0000);
    st(4'h0, 3'h2, 4'h4);
    be <= 1'b0;
    hb <= 1'b0;
    $display("test port done");
    summarize;
  end
endmodule : hpcb_core_bench
